// ===== adcc_defs.vh
/*
 Constants for the converter control block: register address, bit
 positions, reset value, start modes, sequence lengths.
 Assumes inclusion by bare name from the design files of this folder.
*/
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

`define ADCC_CTRL_ADDR      8'he8
`define ADCC_CTRL_RESET     8'h00
`define ADCC_BIT_BASE_HI    5'h1d
`define ADCC_RDATA_NONE     8'h00

`define ADCC_B_ENABLE       7
`define ADCC_B_TRACK_MODE   6
`define ADCC_B_DONE         5
`define ADCC_B_BUSY         4
`define ADCC_B_MODE_HI      3
`define ADCC_B_MODE_LO      2
`define ADCC_B_WINDOW       1
`define ADCC_B_LJUST        0

`define ADCC_MODE_SW        2'h0
`define ADCC_MODE_TMR3      2'h1
`define ADCC_MODE_EXT       2'h2
`define ADCC_MODE_TMR2      2'h3

`define ADCC_DIV_SEL_2      2'h0
`define ADCC_DIV_SEL_4      2'h1
`define ADCC_DIV_SEL_8      2'h2
`define ADCC_DIV_SEL_16     2'h3
`define ADCC_DIV_LAST_2     4'h1
`define ADCC_DIV_LAST_4     4'h3
`define ADCC_DIV_LAST_8     4'h7
`define ADCC_DIV_LAST_16    4'hf

`define ADCC_TRACK_CLKS     5'h03
`define ADCC_CONV_CLKS      5'h10
`define ADCC_RES_W          10
`define ADCC_PAD_ZERO       6'h00

`endif

// ===== adcc_clkdiv.v
/*
 Converter clock tick generator: one-cycle tick every 2, 4, 8 or 16
 system clocks. Assumes sel is stable or that a glitch in one period is
 harmless.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_clkdiv (
  input  wire       ref_clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire [1:0] div_sel,
  output reg        sar_tick_q
);

  reg [3:0] cnt_q;
  reg [3:0] last;

  always @* begin
    if (div_sel == `ADCC_DIV_SEL_2) begin
      last = `ADCC_DIV_LAST_2;
    end else if (div_sel == `ADCC_DIV_SEL_4) begin
      last = `ADCC_DIV_LAST_4;
    end else if (div_sel == `ADCC_DIV_SEL_8) begin
      last = `ADCC_DIV_LAST_8;
    end else begin
      last = `ADCC_DIV_LAST_16;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 4'h0;
      sar_tick_q <= 1'b0;
    end else if (clk_en) begin
      if (cnt_q >= last) begin
        cnt_q      <= 4'h0;
        sar_tick_q <= 1'b1;
      end else begin
        cnt_q      <= cnt_q + 4'h1;
        sar_tick_q <= 1'b0;
      end
    end
  end

endmodule // adcc_clkdiv
`default_nettype wire

// ===== adcc_top.v
/*
 Converter control: control register on the special function register
 port (byte and bit access), start triggers, track and convert sequence,
 flags, interrupt request, result justification, window compare.
 Assumes timer overflows and sfr strobes are one-cycle pulses on ref_clk;
 ext_convert_start is an asynchronous pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_top (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire [7:0]  sfr_addr,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  input  wire [7:0]  sfr_bit_addr,
  input  wire        sfr_bit_wr,
  input  wire        sfr_bit_wdata,
  output reg  [7:0]  sfr_rdata,
  input  wire        timer3_ovf,
  input  wire        timer2_ovf,
  input  wire        ext_convert_start,
  input  wire [1:0]  sar_div_sel,
  input  wire        conv_irq_enable,
  input  wire [9:0]  core_result,
  input  wire [9:0]  window_gt_limit,
  input  wire [9:0]  window_lt_limit,
  output reg         conv_power_on,
  output reg         track_on,
  output reg         conv_start,
  output reg         conv_irq,
  output reg  [7:0]  result_high_byte,
  output reg  [7:0]  result_low_byte
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_TRACK = 2'h1;
  localparam [1:0] ST_CONV  = 2'h2;

  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [4:0]  cnt_q;
  reg  [4:0]  cnt_d;
  reg         enable_q;
  reg         track_mode_q;
  reg         done_q;
  reg  [1:0]  mode_q;
  reg         window_q;
  reg         ljust_q;
  reg  [9:0]  result_q;
  reg         ext_s1_q;
  reg         ext_s2_q;
  reg         ext_prev_q;
  wire        sar_tick;

  reg  [7:0]  wmask;
  reg  [7:0]  wval;
  reg         enable_n;
  reg         track_mode_n;
  reg  [1:0]  mode_n;
  reg         trigger;
  reg         finish;
  reg         win_match;
  wire [7:0]  ctrl_byte;
  wire [2:0]  bit_idx;

  assign bit_idx   = sfr_bit_addr[2:0];
  assign ctrl_byte = {enable_q, track_mode_q, done_q, (state_q != ST_IDLE),
                      mode_q, window_q, ljust_q};

  adcc_clkdiv u_clkdiv (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .div_sel    (sar_div_sel),
    .sar_tick_q (sar_tick)
  );

  // byte write wins over a bit write in the same cycle
  always @* begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (sfr_wr && (sfr_addr == `ADCC_CTRL_ADDR)) begin
      wmask = 8'hff;
      wval  = sfr_wdata;
    end else if (sfr_bit_wr && (sfr_bit_addr[7:3] == `ADCC_BIT_BASE_HI)) begin
      wmask = 8'h01 << bit_idx;
      wval  = {8{sfr_bit_wdata}} & wmask;
    end
  end

  always @* begin
    enable_n     = wmask[`ADCC_B_ENABLE] ? wval[`ADCC_B_ENABLE] : enable_q;
    track_mode_n = wmask[`ADCC_B_TRACK_MODE] ? wval[`ADCC_B_TRACK_MODE] : track_mode_q;
    mode_n[1]    = wmask[`ADCC_B_MODE_HI] ? wval[`ADCC_B_MODE_HI] : mode_q[1];
    mode_n[0]    = wmask[`ADCC_B_MODE_LO] ? wval[`ADCC_B_MODE_LO] : mode_q[0];
  end

  // start trigger selection
  always @* begin
    trigger = 1'b0;
    case (mode_q)
      `ADCC_MODE_SW:   trigger = 1'b0;
      `ADCC_MODE_TMR3: trigger = timer3_ovf;
      `ADCC_MODE_EXT:  trigger = ext_s2_q & ~ext_prev_q;
      default:         trigger = timer2_ovf;
    endcase
    if (wmask[`ADCC_B_BUSY] && wval[`ADCC_B_BUSY] && (mode_n == `ADCC_MODE_SW)) begin
      trigger = 1'b1;
    end
    if (!enable_q) begin
      trigger = 1'b0;
    end
  end

  // track and convert sequence
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    finish  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 5'h00;
        if (trigger) begin
          if (track_mode_q && (mode_q != `ADCC_MODE_EXT)) begin
            state_d = ST_TRACK;
          end else begin
            state_d = ST_CONV;
          end
        end
      end
      ST_TRACK: begin
        if (sar_tick) begin
          if (cnt_q == `ADCC_TRACK_CLKS - 5'h01) begin
            cnt_d   = 5'h00;
            state_d = ST_CONV;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      ST_CONV: begin
        if (sar_tick) begin
          if (cnt_q == `ADCC_CONV_CLKS - 5'h01) begin
            cnt_d   = 5'h00;
            state_d = ST_IDLE;
            finish  = 1'b1;
          end else begin
            cnt_d = cnt_q + 5'h01;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 5'h00;
      end
    endcase
    if (!enable_q) begin
      state_d = ST_IDLE;
      cnt_d   = 5'h00;
      finish  = 1'b0;
    end
  end

  // in-band when limits are ordered, out-of-band otherwise
  always @* begin
    if (window_lt_limit > window_gt_limit) begin
      win_match = (core_result > window_gt_limit) && (core_result < window_lt_limit);
    end else begin
      win_match = (core_result > window_gt_limit) || (core_result < window_lt_limit);
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
    end else if (clk_en) begin
      ext_s1_q   <= ext_convert_start;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 5'h00;
      enable_q     <= 1'b0;
      track_mode_q <= 1'b0;
      done_q       <= 1'b0;
      mode_q       <= `ADCC_MODE_SW;
      window_q     <= 1'b0;
      ljust_q      <= 1'b0;
      result_q     <= 10'h000;
    end else if (clk_en) begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      enable_q     <= enable_n;
      track_mode_q <= track_mode_n;
      mode_q       <= mode_n;
      if (wmask[`ADCC_B_LJUST]) begin
        ljust_q <= wval[`ADCC_B_LJUST];
      end
      // hardware set wins over a software clear
      if (finish) begin
        done_q <= 1'b1;
      end else if (wmask[`ADCC_B_DONE] && !wval[`ADCC_B_DONE]) begin
        done_q <= 1'b0;
      end
      if (finish && win_match) begin
        window_q <= 1'b1;
      end else if (wmask[`ADCC_B_WINDOW] && !wval[`ADCC_B_WINDOW]) begin
        window_q <= 1'b0;
      end
      if (finish) begin
        result_q <= core_result;
      end
    end
  end

  // registered outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata        <= `ADCC_RDATA_NONE;
      conv_power_on    <= 1'b0;
      track_on         <= 1'b0;
      conv_start       <= 1'b0;
      conv_irq         <= 1'b0;
      result_high_byte <= 8'h00;
      result_low_byte  <= 8'h00;
    end else if (clk_en) begin
      if (sfr_rd && (sfr_addr == `ADCC_CTRL_ADDR)) begin
        sfr_rdata <= ctrl_byte;
      end else begin
        sfr_rdata <= `ADCC_RDATA_NONE;
      end
      conv_power_on <= enable_q;
      if (!enable_q) begin
        track_on <= 1'b0;
      end else if (!track_mode_q) begin
        track_on <= (state_q == ST_IDLE);
      end else if (mode_q == `ADCC_MODE_EXT) begin
        track_on <= ~ext_s2_q && (state_q == ST_IDLE);
      end else begin
        track_on <= (state_q == ST_TRACK);
      end
      conv_start <= (state_q != ST_CONV) && (state_d == ST_CONV);
      conv_irq   <= finish && conv_irq_enable;
      if (ljust_q) begin
        {result_high_byte, result_low_byte} <= {result_q, `ADCC_PAD_ZERO};
      end else begin
        {result_high_byte, result_low_byte} <= {`ADCC_PAD_ZERO, result_q};
      end
    end
  end

endmodule // adcc_top
`default_nettype wire

// ===== adcc_assertions.sv
/* Port-level properties of the converter control block.
   Bound into every adcc_top; one clock domain, async low reset. */
`timescale 1ns/1ps
`default_nettype none
module adcc_chk (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       conv_irq_enable,
  input wire logic       conv_power_on,
  input wire logic       conv_start,
  input wire logic       conv_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  power_follow_a:
    assert property (sfr_wr && sfr_addr == 8'he8 && clk_en ##1 clk_en
      |=> conv_power_on == $past(sfr_wdata[7], 2)) else $error("power state wrong");
  start_powered_a:
    assert property (conv_start |-> conv_power_on) else $error("start while off");
  start_pulse_a:
    assert property (conv_start |=> !conv_start) else $error("start too long");
  irq_pulse_a:
    assert property (conv_irq |=> !conv_irq) else $error("irq too long");
  irq_gated_a:
    assert property (conv_irq |-> $past(conv_irq_enable)) else $error("irq not enabled");
  conv_min_len_a:
    assert property (conv_start |-> !conv_irq [*8]) else $error("conversion too short");
  rdata_idle_a:
    assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00) else $error("rdata not idle");
  rdata_unmapped_a:
    assert property ($past(sfr_rd) && $past(sfr_addr) != 8'he8 |-> sfr_rdata == 8'h00)
      else $error("unmapped read data");
endmodule // adcc_chk

bind adcc_top adcc_chk u_chk (.ref_clk, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .conv_irq_enable, .conv_power_on, .conv_start, .conv_irq);
`default_nettype wire

// ===== adcc_core_model.sv
/* Behavioural converter core: holds a value chosen at conversion start.
   Assumes start is a one-cycle pulse on ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model (
  input  wire logic       ref_clk,
  input  wire logic       powered,
  input  wire logic       start,
  input  wire logic [9:0] next_val,
  output wire logic [9:0] result
);
  logic [9:0] held_q = 10'h000;
  logic [9:0] res_q = 10'h000;
  assign result = res_q;
  always @(posedge ref_clk) begin
    if (start)
      held_q <= next_val;
    // shut down core gives no stable value
    res_q <= powered ? held_q : ~res_q;
  end
endmodule // adcc_core_model
`default_nettype wire

// ===== testbench.sv
/* Random self-checking bench for adcc_top with the core model.
   Assumes the checker is bound through its own file. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       ref_clk, rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_wdata, tm, lj, clk_en;
  logic       timer3_ovf, timer2_ovf, ext_convert_start, conv_irq_enable;
  logic       conv_power_on, track_on, conv_start, conv_irq;
  logic [1:0] sar_div_sel, m;
  logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, result_high_byte, result_low_byte, d;
  logic [9:0] core_result, window_gt_limit, window_lt_limit, next_val;
  logic [15:0] e;
  int         errors, tests_run, n, k, dv, irq_base;
  int         irq_cnt = 0;
  adcc_top uut (.ref_clk, .rst_n, .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_bit_addr, .sfr_bit_wr, .sfr_bit_wdata, .sfr_rdata, .timer3_ovf, .timer2_ovf,
    .ext_convert_start, .sar_div_sel, .conv_irq_enable, .core_result, .window_gt_limit,
    .window_lt_limit, .conv_power_on, .track_on, .conv_start, .conv_irq,
    .result_high_byte, .result_low_byte);
  adcc_core_model u_core (.ref_clk, .powered(conv_power_on), .start(conv_start), .next_val,
    .result(core_result));
  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end
  // counts pulses so that a doubled request shows up too
  always @(posedge ref_clk) if (conv_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  task automatic print_verdict();
    if (errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int c = 1);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] v);
    sfr_addr = 8'he8;
    sfr_wdata = v;
    sfr_wr = 1;
    tick();
    sfr_wr = 0;
  endtask
  task automatic bw(input logic [2:0] b, input logic v);
    sfr_bit_addr = {5'h1d, b};
    sfr_bit_wdata = v;
    sfr_bit_wr = 1;
    tick();
    sfr_bit_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1;
    tick();
    sfr_rd = 0;
    d = sfr_rdata;
    // idle cycle keeps back-to-back reads from re-raising the strobe at once
    tick();
  endtask
  function automatic logic win(input logic [9:0] r, input logic [9:0] gt, input logic [9:0] lt);
    return (lt > gt) ? (r > gt && r < lt) : (r > gt || r < lt);
  endfunction
  initial begin
    {rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_wdata, timer3_ovf, timer2_ovf} = '0;
    clk_en = 1'b1;
    {ext_convert_start, conv_irq_enable, sar_div_sel, sfr_addr, sfr_wdata, sfr_bit_addr} = '0;
    {next_val, window_gt_limit, window_lt_limit, errors, tests_run} = '0;
    void'($urandom(34293));
    tick(3);
    rst_n = 1;
    rd(8'he8);
    check("reset value", d, 8'h00);
    rd(8'h55);
    check("unmapped", d, 8'h00);
    for (int i = 0; i < 24; i++) begin
      m = i[1:0];
      tm = 1'($urandom);
      lj = 1'($urandom);
      sar_div_sel = 2'($urandom);
      dv = 2 << sar_div_sel;
      conv_irq_enable = 1'($urandom);
      next_val = 10'($urandom);
      window_gt_limit = 10'($urandom);
      window_lt_limit = 10'($urandom);
      wr({1'b1, tm, 2'b00, m, 1'b0, lj});
      tick(4);
      check("power", conv_power_on, 8'h01);
      check("idle track", track_on, !tm || m == 2'h2);
      if (m != 2'h0) begin
        bw(3'h4, 1'b1);
        tick(2);
        rd(8'he8);
        check("busy ignored", d[4], 8'h00);
      end
      irq_base = irq_cnt;
      timer3_ovf = m == 2'h1;
      timer2_ovf = m == 2'h3;
      ext_convert_start = m == 2'h2;
      sfr_bit_addr = 8'hec;
      sfr_bit_wdata = 1'b1;
      sfr_bit_wr = m == 2'h0;
      tick();
      {timer3_ovf, timer2_ovf, sfr_bit_wr} = 3'b000;
      n = 0;
      for (k = 0; k < 400 && conv_start !== 1'b1; k++) begin
        n += track_on;
        tick();
      end
      check("started", conv_start, 8'h01);
      // n excludes the edge that launches conv_start: 3 ticks span 2*dv+1 to 3*dv clocks
      if (tm && m != 2'h2) check("track len", n >= 2 * dv && n < 3 * dv, 8'h01);
      rd(8'he8);
      check("busy", d[4], 8'h01);
      for (k = 0; k < 300 && d[4] !== 1'b0; k++)
        rd(8'he8);
      tick();
      e = lj ? {next_val, 6'h00} : {6'h00, next_val};
      check("done", d[5], 8'h01);
      check("window", d[1], win(next_val, window_gt_limit, window_lt_limit));
      check("irq", 8'(irq_cnt - irq_base), {7'h00, conv_irq_enable});
      check("res hi", result_high_byte, e[15:8]);
      check("res lo", result_low_byte, e[7:0]);
      bw(3'h5, 1'b1);
      rd(8'he8);
      check("done kept", d[5], 8'h01);
      bw(3'h5, 1'b0);
      rd(8'he8);
      check("done clear", d[5], 8'h00);
      if (tm && m == 2'h2) check("pin high", track_on, 8'h00);
      ext_convert_start = 0;
    end
    wr(8'h00);
    bw(3'h4, 1'b1);
    tick(2);
    check("power off", conv_power_on, 8'h00);
    rd(8'he8);
    check("off busy", d, 8'h00);
    // frozen clock enable: an enabling write must not be taken
    clk_en = 1'b0;
    wr(8'h80);
    tick(2);
    check("frozen power", conv_power_on, 8'h00);
    clk_en = 1'b1;
    rd(8'he8);
    check("frozen write", d, 8'h00);
    print_verdict();
  end
  initial begin
    #(40 * 40000);
    errors++;
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
